// [common/two_wire_pkg.sv]
`default_nettype none
package two_wire_pkg;
	// ----------------------------------------
	// Addressing
	// ----------------------------------------
	localparam logic [6:0] SLAVE_ADDR     = 7'h74;
	localparam logic [7:0] REG_ADDR_MAX   = 8'h7F;
	localparam logic [7:0] REG_ADDR_FIRST = 8'h00;
	localparam logic [7:0] REG_RESET_VAL  = 8'h00;
	localparam int         REG_COUNT      = 128;
	localparam int         BYTE_BITS      = 8;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int MCLK_PERIOD_PS = 4000;
	localparam int BUF_FREE_STD_NS = 4700;
	localparam int BUF_FREE_FAST_NS = 1300;
	localparam int BUF_FREE_STD_CYC = (BUF_FREE_STD_NS * 1000 + MCLK_PERIOD_PS - 1) / MCLK_PERIOD_PS;
	localparam int BUF_FREE_FAST_CYC = (BUF_FREE_FAST_NS * 1000 + MCLK_PERIOD_PS - 1) / MCLK_PERIOD_PS;
	localparam int SCL_HALF_CYC = 50;
endpackage : two_wire_pkg
`default_nettype wire

// [common/two_wire_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface two_wire_if;
	logic scl_o;
	logic scl_oe;
	logic sda_m_o;
	logic sda_m_oe;
	logic sda_s_o;
	logic sda_s_oe;
	wire  scl;
	wire  sda;
	// Open-drain wired-AND; an undriven line rests high.
	assign scl = !(scl_oe && !scl_o);
	assign sda = !((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o));
	modport master (output scl_o, output scl_oe, output sda_m_o, output sda_m_oe, input scl, input sda);
	modport slave  (output sda_s_o, output sda_s_oe, input scl, input sda);
endinterface : two_wire_if
`default_nettype wire

// [rtl/two_wire_slave.sv]
`timescale 1ns/1ps
`default_nettype none
module two_wire_slave
	import two_wire_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       rst_n,
	two_wire_if.slave       bus,
	output var  logic       wr_valid_r,
	output var  logic [7:0] wr_addr_r,
	output var  logic [7:0] wr_data_r,
	output var  logic       busy_r
);
	// ----------------------------------------
	// Types and state
	// ----------------------------------------
	typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_REG, ST_DATA, ST_ACK, ST_IGNORE} state_t;
	typedef enum logic [1:0] {PH_DEV, PH_REG, PH_DATA} phase_t;

	state_t     state_r;
	phase_t     phase_r;
	logic [1:0] scl_sync_r;
	logic [1:0] sda_sync_r;
	logic       scl_d_r;
	logic       sda_d_r;
	logic [7:0] shift_r;
	logic [3:0] bit_cnt_r;
	logic [7:0] ptr_r;
	logic       sda_oe_r;

	// ----------------------------------------
	// Edge and condition detection
	// ----------------------------------------
	wire scl_rise  = scl_sync_r[1] && !scl_d_r;
	wire scl_fall  = !scl_sync_r[1] && scl_d_r;
	wire start_det = scl_sync_r[1] && scl_d_r && sda_d_r && !sda_sync_r[1];
	wire stop_det  = scl_sync_r[1] && scl_d_r && !sda_d_r && sda_sync_r[1];

	function automatic logic [7:0] next_ptr(input logic [7:0] p);
		if (p >= REG_ADDR_MAX)
		begin
			next_ptr = REG_ADDR_FIRST;
		end
		else
		begin
			next_ptr = p + 8'h01;
		end
	endfunction : next_ptr

	// ----------------------------------------
	// Elaboration checks
	// ----------------------------------------
	if (BYTE_BITS != 8)
	begin : g_bad_byte
		$error("Byte width must be eight bits.");
	end
	if (REG_COUNT != int'(REG_ADDR_MAX) + 1)
	begin : g_bad_count
		$error("Register count must match the last address.");
	end
	if (REG_ADDR_FIRST > REG_ADDR_MAX)
	begin : g_bad_first
		$error("First address must not exceed the last address.");
	end
	if (REG_COUNT > 256)
	begin : g_bad_span
		$error("Register span must fit the address byte.");
	end

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			scl_sync_r <= 2'h3;
			sda_sync_r <= 2'h3;
			scl_d_r    <= 1'b1;
			sda_d_r    <= 1'b1;
		end
		else
		begin
			scl_sync_r <= {scl_sync_r[0], bus.scl};
			sda_sync_r <= {sda_sync_r[0], bus.sda};
			scl_d_r    <= scl_sync_r[1];
			sda_d_r    <= sda_sync_r[1];
		end
	end

	// ----------------------------------------
	// Bus state machine
	// ----------------------------------------
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			state_r    <= ST_IDLE;
			phase_r    <= PH_DEV;
			shift_r    <= 8'h00;
			bit_cnt_r  <= 4'h0;
			ptr_r      <= REG_ADDR_FIRST;
			sda_oe_r   <= 1'b0;
			wr_valid_r <= 1'b0;
			wr_addr_r  <= REG_ADDR_FIRST;
			wr_data_r  <= REG_RESET_VAL;
			busy_r     <= 1'b0;
		end
		else
		begin
			wr_valid_r <= 1'b0;
			if (start_det)
			begin
				state_r   <= ST_ADDR;
				phase_r   <= PH_DEV;
				bit_cnt_r <= 4'h0;
				sda_oe_r  <= 1'b0;
				busy_r    <= 1'b1;
			end
			else if (stop_det)
			begin
				state_r  <= ST_IDLE;
				sda_oe_r <= 1'b0;
				busy_r   <= 1'b0;
			end
			else
			begin
				case (state_r)
					ST_IDLE:
					begin
						sda_oe_r <= 1'b0;
					end
					ST_ADDR, ST_REG, ST_DATA:
					begin
						if (scl_rise)
						begin
							shift_r   <= {shift_r[6:0], sda_sync_r[1]};
							bit_cnt_r <= bit_cnt_r + 4'h1;
						end
						else if (scl_fall && bit_cnt_r == 4'(BYTE_BITS))
						begin
							bit_cnt_r <= 4'h0;
							if (state_r == ST_ADDR)
							begin
								if (shift_r[7:1] == SLAVE_ADDR && !shift_r[0])
								begin
									sda_oe_r <= 1'b1;
									state_r  <= ST_ACK;
									phase_r  <= PH_REG;
								end
								else
								begin
									state_r <= ST_IGNORE;
								end
							end
							else if (state_r == ST_REG)
							begin
								ptr_r    <= shift_r;
								sda_oe_r <= 1'b1;
								state_r  <= ST_ACK;
								phase_r  <= PH_DATA;
							end
							else
							begin
								wr_valid_r <= 1'b1;
								wr_addr_r  <= ptr_r;
								wr_data_r  <= shift_r;
								ptr_r      <= next_ptr(ptr_r);
								sda_oe_r   <= 1'b1;
								state_r    <= ST_ACK;
							end
						end
					end
					ST_ACK:
					begin
						if (scl_fall)
						begin
							sda_oe_r <= 1'b0;
							state_r  <= (phase_r == PH_REG) ? ST_REG : ST_DATA;
						end
					end
					default:
					begin
						sda_oe_r <= 1'b0;
					end
				endcase
			end
		end
	end

	// ----------------------------------------
	// Line drivers
	// ----------------------------------------
	assign bus.sda_s_o  = 1'b0;
	assign bus.sda_s_oe = sda_oe_r;
endmodule : two_wire_slave
`default_nettype wire

// [rtl/two_wire_master.sv]
`timescale 1ns/1ps
`default_nettype none
module two_wire_master
	import two_wire_pkg::*;
#(
	parameter int HALF_CYC = SCL_HALF_CYC
)
(
	input  wire logic       mclk,
	input  wire logic       rst_n,
	two_wire_if.master      bus,
	input  wire logic       req,
	input  wire logic       fast_mode,
	input  wire logic [7:0] req_byte,
	input  wire logic       req_last,
	output var  logic       byte_done_r,
	output var  logic       nack_r,
	output var  logic       idle_r
);
	// ----------------------------------------
	// Elaboration checks
	// ----------------------------------------
	if (HALF_CYC < 2 || HALF_CYC > 65535)
	begin : g_bad_half
		$error("HALF_CYC out of range");
	end

	typedef enum logic [2:0] {M_IDLE, M_START, M_BIT, M_ACK, M_STOP, M_FREE} mstate_t;

	mstate_t     st_r;
	logic [15:0] tmr_r;
	logic [1:0]  ph_r;
	logic [7:0]  sh_r;
	logic [3:0]  bits_r;
	logic        last_r;
	logic        scl_r;
	logic        sda_r;
	logic [1:0]  sda_sync_r;

	// ----------------------------------------
	// SDA synchroniser and byte sequencer
	// ----------------------------------------
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			sda_sync_r <= 2'h3;
		end
		else
		begin
			sda_sync_r <= {sda_sync_r[0], bus.sda};
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			st_r <= M_IDLE;
			tmr_r <= 16'h0000;
			ph_r <= 2'h0;
			sh_r <= 8'h00;
			bits_r <= 4'h0;
			last_r <= 1'b0;
			scl_r <= 1'b1;
			sda_r <= 1'b1;
			byte_done_r <= 1'b0;
			nack_r <= 1'b0;
			idle_r <= 1'b1;
		end
		else
		begin
			byte_done_r <= 1'b0;
			if (st_r != M_IDLE && tmr_r != 16'h0000)
			begin
				tmr_r <= tmr_r - 16'h0001;
			end
			else
			begin
				tmr_r <= 16'(HALF_CYC - 1);
				case (st_r)
					M_IDLE:
					begin
						if (req)
						begin
							sda_r <= 1'b0;
							sh_r <= req_byte;
							last_r <= req_last;
							bits_r <= 4'h0;
							ph_r <= 2'h0;
							idle_r <= 1'b0;
							st_r <= M_START;
						end
					end
					M_START:
					begin
						scl_r <= 1'b0;
						st_r <= M_BIT;
					end
					M_BIT:
					begin
						ph_r <= ph_r + 2'h1;
						if (ph_r == 2'h0)
						begin
							sda_r <= sh_r[7];
						end
						else if (ph_r == 2'h1)
						begin
							scl_r <= 1'b1;
						end
						else
						begin
							scl_r <= 1'b0;
							ph_r <= 2'h0;
							sh_r <= {sh_r[6:0], 1'b0};
							bits_r <= bits_r + 4'h1;
							if (bits_r == 4'(BYTE_BITS - 1))
							begin
								sda_r <= 1'b1;
								st_r <= M_ACK;
							end
						end
					end
					M_ACK:
					begin
						ph_r <= ph_r + 2'h1;
						if (ph_r == 2'h1)
						begin
							scl_r <= 1'b1;
						end
						else if (ph_r == 2'h2)
						begin
							nack_r <= sda_sync_r[1];
							scl_r <= 1'b0;
							ph_r <= 2'h0;
							byte_done_r <= 1'b1;
							if (last_r || sda_sync_r[1])
							begin
								sda_r <= 1'b0;
								st_r <= M_STOP;
							end
							else if (req)
							begin
								sh_r <= req_byte;
								last_r <= req_last;
								bits_r <= 4'h0;
								st_r <= M_BIT;
							end
							else
							begin
								sda_r <= 1'b0;
								st_r <= M_STOP;
							end
						end
					end
					M_STOP:
					begin
						ph_r <= ph_r + 2'h1;
						if (ph_r == 2'h0)
						begin
							scl_r <= 1'b1;
						end
						else
						begin
							sda_r <= 1'b1;
							ph_r <= 2'h0;
							tmr_r <= 16'(fast_mode ? BUF_FREE_FAST_CYC : BUF_FREE_STD_CYC);
							st_r <= M_FREE;
						end
					end
					default:
					begin
						idle_r <= 1'b1;
						st_r <= M_IDLE;
					end
				endcase
			end
		end
	end

	assign bus.scl_o = 1'b0;
	assign bus.scl_oe = !scl_r;
	assign bus.sda_m_o = 1'b0;
	assign bus.sda_m_oe = !sda_r;
endmodule : two_wire_master
`default_nettype wire

// [dv/two_wire_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module two_wire_assertions
	import two_wire_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic scl,
	input wire logic sda,
	input wire logic scl_oe,
	input wire logic sda_m_oe,
	input wire logic sda_s_oe
);
	logic       sda_r;
	logic [9:0] gap_r;
	always_ff @(posedge mclk)
	begin
		sda_r <= sda;
		if (!rst_n)
			gap_r <= 10'h3FF;
		else if (scl && !sda_r && sda)
			gap_r <= 10'h000;
		else if (gap_r != 10'h3FF)
			gap_r <= gap_r + 10'h001;
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	sequence start_s; scl && $fell(sda); endsequence
	sequence stop_s; scl && $rose(sda); endsequence
	a_reset_release: assert property ($rose(rst_n) |-> !sda_s_oe && !scl_oe && !sda_m_oe)
		else $error("line driven after reset");
	a_reset_lines_high: assert property ($rose(rst_n) |-> scl && sda)
		else $error("lines low after reset");
	a_ack_starts_low: assert property ($rose(sda_s_oe) |-> !scl)
		else $error("ack begun with clock high");
	a_ack_ends_low: assert property ($fell(sda_s_oe) |-> !scl)
		else $error("ack released with clock high");
	a_ack_held: assert property ($rose(sda_s_oe) |-> ##[1:400] (scl && sda_s_oe))
		else $error("ack not held into ninth clock");
	a_stop_idle: assert property (stop_s |=> (!scl_oe && !sda_s_oe)[*8])
		else $error("line driven after stop");
	a_start_quiet: assert property (start_s |-> (!sda_s_oe)[*8])
		else $error("data driven at start");
	a_bus_free: assert property (start_s |-> gap_r >= BUF_FREE_FAST_CYC - 1)
		else $error("bus free time too short");
endmodule : two_wire_assertions
`default_nettype wire

// [dv/led_driver_i2c_slave_port_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin num_errors++; \
	$display("wrong value t=%0t got %h exp %h", $time, a, e); end end
module led_driver_i2c_slave_port_tb_top
	import two_wire_pkg::*;
;
	logic        mclk, rst_n, req, fast_mode, req_last;
	logic        wr_valid_r, busy_r, byte_done_r, nack_r, idle_r;
	logic [7:0]  req_byte, wr_addr_r, wr_data_r;
	logic [15:0] got[$];
	int          num_errors, checks_done;
	two_wire_if bus();
	two_wire_slave two_wire_slave_inst(.mclk(mclk), .rst_n(rst_n), .bus(bus), .wr_valid_r(wr_valid_r),
		.wr_addr_r(wr_addr_r), .wr_data_r(wr_data_r), .busy_r(busy_r));
	two_wire_master #(.HALF_CYC(8)) two_wire_master_inst(.mclk(mclk), .rst_n(rst_n), .bus(bus), .req(req),
		.fast_mode(fast_mode), .req_byte(req_byte), .req_last(req_last), .byte_done_r(byte_done_r),
		.nack_r(nack_r), .idle_r(idle_r));
	two_wire_assertions two_wire_assertions_inst(.mclk(mclk), .rst_n(rst_n), .scl(bus.scl), .sda(bus.sda),
		.scl_oe(bus.scl_oe), .sda_m_oe(bus.sda_m_oe), .sda_s_oe(bus.sda_s_oe));
	initial
	begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	always @(negedge mclk)
		if (wr_valid_r === 1'b1)
			got.push_back({wr_addr_r, wr_data_r});
	task final_report();
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : final_report
	task put(input logic [7:0] b, input logic last);
		@(negedge mclk);
		req = 1'b1;
		req_byte = b;
		req_last = last;
	endtask : put
	task wait_done();
		int n;
		n = 0;
		@(negedge mclk);
		while (byte_done_r !== 1'b1 && n < 4000)
		begin
			@(negedge mclk);
			n++;
		end
		`CHK(n < 4000, 1'b1)
	endtask : wait_done
	task idle_wait();
		int n;
		n = 0;
		repeat (4) @(negedge mclk);
		while (idle_r !== 1'b1 && n < 4000)
		begin
			@(negedge mclk);
			n++;
		end
		repeat (8) @(negedge mclk);
		`CHK(busy_r, 1'b0)
		`CHK(bus.scl & bus.sda, 1'b1)
	endtask : idle_wait
	task access(input logic [7:0] ra, input int cnt, input logic [7:0] d0);
		int i;
		got = {};
		put({SLAVE_ADDR, 1'b0}, 1'b0);
		put(ra, 1'b0);
		wait_done();
		`CHK(nack_r, 1'b0)
		`CHK(busy_r, 1'b1)
		for (i = 0; i < cnt; i++)
		begin
			put(d0 + i[7:0], i == cnt - 1);
			wait_done();
		end
		wait_done();
		req = 1'b0;
		idle_wait();
		`CHK(got.size(), cnt)
		for (i = 0; i < cnt; i++)
			`CHK(got[i], {(ra + i[7:0]) & REG_ADDR_MAX, d0 + i[7:0]})
	endtask : access
	task refused(input logic [7:0] first);
		got = {};
		put(first, 1'b1);
		wait_done();
		req = 1'b0;
		`CHK(nack_r, 1'b1)
		idle_wait();
		`CHK(got.size(), 0)
	endtask : refused
	initial
	begin
		rst_n = 1'b0;
		req = 1'b0;
		fast_mode = 1'b0;
		req_last = 1'b0;
		req_byte = 8'h00;
		num_errors = 0;
		checks_done = 0;
		repeat (10) @(negedge mclk);
		`CHK(busy_r, 1'b0)
		rst_n = 1'b1;
		access(8'h7E, 3, 8'hA5);
		fast_mode = 1'b1;
		access(8'h10, 2, 8'h3C);
		refused({SLAVE_ADDR ^ 7'h01, 1'b0});
		refused({SLAVE_ADDR, 1'b1});
		@(negedge mclk);
		req = 1'b1;
		req_byte = {SLAVE_ADDR, 1'b0};
		req_last = 1'b0;
		repeat (2000) if (bus.sda_s_oe !== 1'b1) @(negedge mclk);
		rst_n = 1'b0;
		req = 1'b0;
		repeat (4) @(negedge mclk);
		`CHK(bus.sda_s_oe, 1'b0)
		`CHK(busy_r, 1'b0)
		`CHK(idle_r, 1'b1)
		rst_n = 1'b1;
		access(8'h7F, 2, 8'h5A);
		final_report();
	end
	initial
	begin
		repeat (40000) @(posedge mclk);
		num_errors++;
		final_report();
	end
endmodule : led_driver_i2c_slave_port_tb_top
`default_nettype wire
